// ---- card_config_registers.sv ----
// Purpose: Register bank for the record tail, configuration record and status.
// Assumes: Plain register port and command requests on ref_clk.
// Notes:   Read data stands only in the cycle after the read strobe.
`timescale 1ns/1ns

module card_config_registers
    import card_cfg_pkg::*;
(
    input  wire logic        ref_clk,   // 100 MHz clock
    input  wire logic        rstn,      // Async reset, active low
    input  wire logic [7:0]  reg_addr,  // Register byte address
    input  wire logic [31:0] reg_wdata, // Write data
    input  wire logic        reg_wr,    // Write strobe
    input  wire logic        reg_rd,    // Read strobe
    output logic      [31:0] reg_rdata, // Read data, cycle after strobe
    input  wire cmd_req_t    cmd,       // Write or erase request
    output logic             cmd_accept, // Request may proceed
    output logic             cmd_reject, // Request refused
    input  wire logic        esb_we,    // Extended status word write
    input  wire logic [3:0]  esb_idx,   // Extended status word index
    input  wire logic [31:0] esb_data   // Extended status word value
);

    // Stored state
    logic              tmp_q;
    logic              tmp_d;
    logic              perm_q;
    logic              perm_d;
    logic              copy_q;
    logic              copy_d;
    logic              fgrp_q;
    logic              fgrp_d;
    format_kind_t      fkind_q;
    format_kind_t      fkind_d;
    logic [6:0]        chk_q;
    logic [6:0]        chk_d;
    logic [31:0]       status_q;
    logic [31:0]       status_d;
    logic [31:0]       rdata_d;
    logic [31:0]       esb_q [ESB_WORDS];

    // Address decode
    wire logic hit_tail   = (reg_addr == OFS_CSD_TAIL);
    wire logic hit_cfg_lo = (reg_addr == OFS_CFG_LO);
    wire logic hit_cfg_hi = (reg_addr == OFS_CFG_HI);
    wire logic hit_status = (reg_addr == OFS_STATUS);
    wire logic hit_format = (reg_addr == OFS_FORMAT);
    wire logic hit_esb    = (reg_addr >= OFS_ESB_BASE) &&
                            (reg_addr <= OFS_ESB_LAST) &&
                            (reg_addr[1:0] == 2'h0);
    wire logic [3:0] esb_rd_idx = reg_addr[5:2];

    // Tail write view
    wire csd_tail_t wr_tail = csd_tail_t'(reg_wdata);
    wire logic      tail_wr = reg_wr && hit_tail;

    // Tail read view
    csd_tail_t rd_tail;
    always_comb
    begin
        rd_tail          = '0;
        rd_tail.tmp      = tmp_q;
        rd_tail.perm     = perm_q;
        rd_tail.copy     = copy_q;
        rd_tail.fgrp     = fgrp_q;
        rd_tail.fkind    = fkind_q;
        rd_tail.partial  = CARD_PARTIAL;
        rd_tail.blk_code = CARD_BLK_CODE;
        rd_tail.checksum = chk_q;
    end

    // Permanent lock and copy flag: one-way bits only ever set; temporary lock follows writes
    assign perm_d  = perm_q || (tail_wr && wr_tail.perm);
    assign copy_d  = copy_q || (tail_wr && wr_tail.copy);
    assign tmp_d   = tail_wr ? wr_tail.tmp : tmp_q;
    assign fgrp_d  = tail_wr ? wr_tail.fgrp : fgrp_q;
    assign fkind_d = tail_wr ? wr_tail.fkind : fkind_q;
    assign chk_d   = tail_wr ? wr_tail.checksum : chk_q;

    // Attempt to undo a one-way bit
    wire logic undo_try = tail_wr && ((perm_q && !wr_tail.perm) ||
                                      (copy_q && !wr_tail.copy));

    // Command gate verdict
    wire logic gate_accept;
    wire logic gate_locked;
    wire logic gate_len_bad;

    write_gate u_gate (
        .req      (cmd),
        .blk_code (CARD_BLK_CODE),
        .partial  (CARD_PARTIAL),
        .perm     (perm_q),
        .tmp      (tmp_q),
        .accept   (gate_accept),
        .locked   (gate_locked),
        .len_bad  (gate_len_bad)
    );

    // Sticky card status bits; a new event beats clear-on-read
    wire logic        status_clr = reg_rd && hit_status;
    wire logic [31:0] status_set = ({31'h0, gate_len_bad} << ST_BLK_LEN_ERR) |
                                   ({31'h0, gate_locked} << ST_WP_VIOL) |
                                   ({31'h0, undo_try} << ST_OVERWRITE);
    assign status_d = (status_clr ? 32'h0000_0000 : status_q) | status_set;

    // Format decode: one-hot kind for group 0, reserved flag for group 1
    wire logic [3:0]  fmt_onehot = fgrp_q ? 4'h0 : (4'h1 << fkind_q);
    wire logic [31:0] fmt_word   = {27'h0, fgrp_q, fmt_onehot};

    // Read multiplexer; unmapped addresses read as zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (reg_rd)
        begin
            if (hit_tail)
                rdata_d = 32'(rd_tail);
            else if (hit_cfg_lo)
                rdata_d = CFG_RECORD[31:0];
            else if (hit_cfg_hi)
                rdata_d = CFG_RECORD[63:32];
            else if (hit_status)
                rdata_d = status_q;
            else if (hit_format)
                rdata_d = fmt_word;
            else if (hit_esb)
                rdata_d = esb_q[esb_rd_idx];
        end
    end

    // Record tail registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tmp_q   <= 1'b0;
            perm_q  <= 1'b0;
            copy_q  <= 1'b0;
            fgrp_q  <= 1'b0;
            fkind_q <= FMT_PARTITIONED;
            chk_q   <= CHK_RST;
        end
        else
        begin
            tmp_q   <= tmp_d;
            perm_q  <= perm_d;
            copy_q  <= copy_d;
            fgrp_q  <= fgrp_d;
            fkind_q <= fkind_d;
            chk_q   <= chk_d;
        end
    end

    // Status, read data and command verdict
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_q   <= 32'h0000_0000;
            reg_rdata  <= 32'h0000_0000;
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
        end
        else
        begin
            status_q   <= status_d;
            reg_rdata  <= rdata_d;
            cmd_accept <= gate_accept;
            cmd_reject <= cmd.valid && !gate_accept;
        end
    end

    // Extended status block, one word per entry
    genvar gi;
    generate
        for (gi = 0; gi < ESB_WORDS; gi++)
        begin : g_esb
            always_ff @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                    esb_q[gi] <= 32'h0000_0000;
                else if (esb_we && (esb_idx == 4'(gi)))
                    esb_q[gi] <= esb_data;
            end
        end
    endgenerate

    // Checks on the block's own behaviour
    a_perm_stays_set: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        perm_q |=> perm_q [*4])
        else $error("permanent lock was cleared");

    a_copy_stays_set: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        copy_q |=> copy_q)
        else $error("copy flag returned to original");

    a_undo_flagged: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (tail_wr && perm_q && !wr_tail.perm) |=> status_q[ST_OVERWRITE] && perm_q)
        else $error("undo of lock not flagged");

    a_lock_refuses: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && !cmd.secure && (perm_q || tmp_q))
        |=> cmd_reject && !cmd_accept && status_q[ST_WP_VIOL])
        else $error("locked card took a command");

    a_tmp_follows: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        tail_wr |=> (tmp_q == $past(wr_tail.tmp)))
        else $error("temporary lock did not follow write");

    a_partial_len: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && !cmd.erase && !gate_locked && !CARD_PARTIAL &&
         (cmd.len[8:0] != 9'h000)) |=> cmd_reject ##1 status_q[ST_BLK_LEN_ERR])
        else $error("partial block accepted");

    a_blk_code_ok: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_tail) |=> (reg_rdata[11:8] >= BLK_CODE_MIN) &&
                                 (reg_rdata[11:8] <= BLK_CODE_MAX))
        else $error("block length code out of range");

    a_cfg_hi_value: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_cfg_hi) |=> (reg_rdata == 32'h0025_0000) &&
                                   (reg_rdata[22:20] != 3'h0))
        else $error("configuration record upper word wrong");

    a_cfg_lo_zero: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_cfg_lo) |=> (reg_rdata == 32'h0000_0000))
        else $error("configuration record lower word not zero");

    a_fmt_reserved: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_format && fgrp_q) |=> reg_rdata[FMT_RSVD_BIT] &&
                                             (reg_rdata[3:0] == 4'h0))
        else $error("group one format not reported reserved");

    a_status_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_status && !cmd.valid && !tail_wr)
        |=> (reg_rdata == $past(status_q)) && (status_q == 32'h0000_0000))
        else $error("status not returned or not cleared");

    a_rdata_idle: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !reg_rd |=> (reg_rdata == 32'h0000_0000))
        else $error("read data outside read answer");

    // Command verdict checks: one verdict per command, length and lock policy
    a_verdict_single: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !(cmd_accept && cmd_reject))
        else $error("command both accepted and refused");

    a_verdict_idle: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !cmd.valid |=> !cmd_accept && !cmd_reject)
        else $error("verdict without a command");

    a_full_block: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && !gate_locked && !cmd.erase && (cmd.len == BLK_UNIT))
        |=> cmd_accept && !cmd_reject)
        else $error("full block write refused");

    a_oversize_len: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && !gate_locked && !cmd.erase && (cmd.len > (BLK_UNIT << (CARD_BLK_CODE - BLK_CODE_MIN))))
        |=> cmd_reject && status_q[ST_BLK_LEN_ERR])
        else $error("block longer than full size accepted");

    a_zero_len: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && !gate_locked && !cmd.erase && (cmd.len == 12'h000))
        |=> cmd_reject && status_q[ST_BLK_LEN_ERR])
        else $error("empty block accepted");

    a_secure_open: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && cmd.secure && !cmd.erase && (cmd.len == BLK_UNIT))
        |=> cmd_accept && !cmd_reject)
        else $error("secured area write refused");

    a_erase_any_len: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && cmd.erase && !gate_locked) |=> cmd_accept)
        else $error("unlocked erase refused");

    a_lock_erase: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (cmd.valid && cmd.erase && !cmd.secure && tmp_q)
        |=> cmd_reject && !cmd_accept)
        else $error("locked card took an erase");

    // Register side checks: one-way bits, sticky status, decode and storage
    a_undo_copy: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (tail_wr && copy_q && !wr_tail.copy) |=> status_q[ST_OVERWRITE] && copy_q)
        else $error("undo of copy flag not flagged");

    a_status_sticky: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !status_clr |=> ((status_q & $past(status_q)) == $past(status_q)))
        else $error("status bit lost without a read");

    a_fmt_kind: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_format && !fgrp_q)
        |=> (reg_rdata == (32'h0000_0001 << $past(fkind_q))))
        else $error("format kind decode wrong");

    a_esb_store: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        esb_we |=> (esb_q[$past(esb_idx)] == $past(esb_data)))
        else $error("extended status word not stored");

    a_tail_fixed: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (reg_rd && hit_tail) |=> (reg_rdata[6] == CARD_PARTIAL) &&
                                 (reg_rdata[31:19] == 13'h0000))
        else $error("read-only tail fields changed");

endmodule // card_config_registers

// ---- card_cfg_pkg.sv ----
// Purpose: Shared constants and types for the card configuration register bank.
// Assumes: Registers take one 32-bit word each, at the byte offsets below.
// Notes:   The configuration record is built here from its field values.
package card_cfg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CSD_TAIL = 8'h00;
    localparam logic [7:0] OFS_CFG_LO   = 8'h04;
    localparam logic [7:0] OFS_CFG_HI   = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_FORMAT   = 8'h10;
    localparam logic [7:0] OFS_ESB_BASE = 8'h40;
    localparam logic [7:0] OFS_ESB_LAST = 8'h7C;
    localparam int         ESB_WORDS    = 16;

    // Write block length coding and card choices
    localparam logic [3:0]  BLK_CODE_MIN = 4'h9;
    localparam logic [3:0]  BLK_CODE_MAX = 4'hB;
    localparam logic [3:0]  CARD_BLK_CODE = 4'h9;
    localparam logic        CARD_PARTIAL = 1'b0;
    localparam logic [11:0] BLK_UNIT     = 12'h200;
    localparam logic [6:0]  CHK_RST      = 7'h00;

    // Card status bit positions
    localparam int ST_BLK_LEN_ERR = 29;
    localparam int ST_WP_VIOL     = 26;
    localparam int ST_OVERWRITE   = 16;

    // Format decode register bit positions
    localparam int FMT_RSVD_BIT = 4;

    // Configuration record fields
    localparam logic [3:0] CFG_LAYOUT = 4'h0;
    localparam logic [3:0] CFG_PHY    = 4'h0;
    localparam logic       CFG_ERASED = 1'b0;
    localparam logic [2:0] CFG_PROT   = 3'h2;
    localparam logic [3:0] CFG_WIDTHS = 4'h5;
    localparam logic [63:0] CFG_RECORD = {CFG_LAYOUT, CFG_PHY, CFG_ERASED,
                                          CFG_PROT, CFG_WIDTHS, 16'h0000,
                                          32'h0000_0000};

    // Format kinds under format group 0
    typedef enum logic [1:0] {
        FMT_PARTITIONED = 2'h0,
        FMT_BOOT_ONLY   = 2'h1,
        FMT_UNIVERSAL   = 2'h2,
        FMT_OTHER       = 2'h3
    } format_kind_t;

    // Tail of the card-specific data record as one register word
    typedef struct packed {
        logic [12:0]  zero;
        logic [6:0]   checksum;
        logic [3:0]   blk_code;
        logic         pad;
        logic         partial;
        format_kind_t fkind;
        logic         fgrp;
        logic         copy;
        logic         perm;
        logic         tmp;
    } csd_tail_t;

    // Write or erase request from the command decoder
    typedef struct packed {
        logic        valid;
        logic        erase;
        logic        secure;
        logic [11:0] len;
    } cmd_req_t;

endpackage

// ---- write_gate.sv ----
// Purpose: Decides whether a write or erase command may proceed.
// Assumes: Request and settings come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the verdict.
`timescale 1ns/1ns
module write_gate
    import card_cfg_pkg::*;
(
    input  wire cmd_req_t   req,      // Incoming command
    input  wire logic [3:0] blk_code, // Write block length exponent
    input  wire logic       partial,  // Partial blocks allowed
    input  wire logic       perm,     // Permanent lock
    input  wire logic       tmp,      // Temporary lock
    output wire logic       accept,   // Command may proceed
    output wire logic       locked,   // Refused by a lock
    output wire logic       len_bad   // Refused by its length
);

    // Full block size from the exponent
    wire logic [1:0]  blk_shift = 2'(blk_code - BLK_CODE_MIN);
    wire logic [11:0] full_len  = BLK_UNIT << blk_shift;

    // Length checks for both partial settings
    wire logic len_fits  = (req.len != 12'h000) && (req.len <= full_len);
    wire logic len_unit  = (req.len[8:0] == 9'h000);
    wire logic len_ok    = len_fits && (partial || len_unit);

    // Locks guard everything outside the secured area
    assign locked  = req.valid && !req.secure && (perm || tmp);
    assign len_bad = req.valid && !locked && !req.erase && !len_ok;
    assign accept  = req.valid && !locked && (req.erase || len_ok);

endmodule // write_gate

// ---- host_cmd_model.sv ----
// Purpose: Host-side model that issues write and erase commands to the card.
// Assumes: The bench stages a request and pulses go for one cycle.
// Notes:   Idle qualifiers toggle every cycle so a stale command never looks valid.
`timescale 1ns/1ns
module host_cmd_model
    import card_cfg_pkg::*;
(
    input  wire logic     ref_clk, // Card clock from the host
    input  wire logic     rstn,    // Async reset, active low
    input  wire logic     go,      // Issue the staged request
    input  wire cmd_req_t req,     // Staged request
    output cmd_req_t      cmd_q    // Command towards the card
);
    // One command per go pulse; between commands the other fields are scrambled
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cmd_q <= '0;
        else if (go)
            cmd_q <= req;
        else
            cmd_q <= {1'b0, ~cmd_q[13:0]};
    end
endmodule // host_cmd_model

// ---- tb_card_config_registers.sv ----
// Purpose: Self-checking bench for the card configuration register bank.
// Assumes: Register port reads answer one cycle after the strobe.
// Notes:   Commands reach the card through the host model, one cycle late.
`timescale 1ns/1ns
module tb_card_config_registers
    import card_cfg_pkg::*;
;
    logic        ref_clk, rstn, reg_wr, reg_rd, go, esb_we, cmd_accept, cmd_reject;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, esb_data;
    logic [3:0]  esb_idx;
    cmd_req_t    req, cmd;
    int          n_mismatch, checks, cycles;
    logic [11:0] lens [5] = '{12'h200, 12'h100, 12'h000, 12'h201, 12'h400};
    logic        oks  [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    card_config_registers DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .esb_we(esb_we), .esb_idx(esb_idx), .esb_data(esb_data));
    host_cmd_model HOST (.ref_clk(ref_clk), .rstn(rstn), .go(go), .req(req), .cmd_q(cmd));

    // Clock at 100 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // Expected record tail word; read-only block code is always 9
    function automatic logic [31:0] tw(logic tmp, logic perm, logic copy, logic grp, logic [1:0] kind,
                                       logic [6:0] chk);
        return {13'h0000, chk, 4'h9, 2'b00, kind, grp, copy, perm, tmp};
    endfunction

    function automatic cmd_req_t mk(logic erase, logic secure, logic [11:0] len);
        return {1'b1, erase, secure, len};
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cmd(input string name, input logic exp, input logic acc, input logic rej);
        checks++;
        if (acc !== exp || rej !== ~exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected accept %b seen accept %b reject %b", name, exp, acc, rej);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read one word and compare it in the single cycle it stands
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_word(name, exp, reg_rdata);
    endtask

    // Stage a command in the host model; the verdict stands one cycle after the card takes it
    task automatic send(input cmd_req_t r, input logic acc, input string name);
        @(posedge ref_clk);
        go  <= 1'b1;
        req <= r;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk_cmd(name, acc, cmd_accept, cmd_reject);
    endtask

    // Main sequence
    initial
    begin
        rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; go = 1'b0; esb_we = 1'b0;
        reg_addr = 8'h00; reg_wdata = 32'h0000_0000; req = '0; esb_idx = 4'h0; esb_data = 32'h0000_0000;
        n_mismatch = 0; checks = 0; cycles = 0;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(OFS_CSD_TAIL, tw(0, 0, 0, 0, 2'h0, 7'h00), "tail_reset");
        rd(OFS_CFG_HI, 32'h0025_0000, "cfg_hi");
        rd(OFS_CFG_LO, 32'h0000_0000, "cfg_lo");
        wr(OFS_CFG_HI, 32'hFFFF_FFFF);
        wr(OFS_CFG_LO, 32'hFFFF_FFFF);
        rd(OFS_CFG_HI, 32'h0025_0000, "cfg_hi_ro");
        rd(OFS_CFG_LO, 32'h0000_0000, "cfg_lo_ro");
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000, "unmapped");
        rd(OFS_STATUS, 32'h0000_0000, "status_reset");
        $display("Test reset_and_record done");
        // Read-only code and partial flag ignore writes; checksum is host-written
        wr(OFS_CSD_TAIL, 32'hFFF5_5FC0);
        rd(OFS_CSD_TAIL, tw(0, 0, 0, 0, 2'h0, 7'h55), "tail_ro");
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_CSD_TAIL, tw(0, 0, 0, 0, k[1:0], 7'h10 + 7'(k)));
            rd(OFS_FORMAT, 32'(1) << k, "format_kind");
        end
        wr(OFS_CSD_TAIL, tw(0, 0, 0, 1, 2'h2, 7'h20));
        rd(OFS_FORMAT, 32'h0000_0010, "format_grp1");
        $display("Test tail_fields done");
        for (int i = 0; i < 5; i++)
            send(mk(0, 0, lens[i]), oks[i], "block_len");
        send(mk(1, 0, 12'h000), 1'b1, "erase_any_len");
        rd(OFS_STATUS, 32'h2000_0000, "status_len");
        rd(OFS_STATUS, 32'h0000_0000, "status_cleared");
        $display("Test block_length done");
        wr(OFS_CSD_TAIL, tw(1, 0, 0, 0, 2'h0, 7'h31));
        send(mk(0, 0, 12'h200), 1'b0, "tmp_write");
        send(mk(1, 0, 12'h000), 1'b0, "tmp_erase");
        send(mk(0, 1, 12'h200), 1'b1, "tmp_secure");
        rd(OFS_STATUS, 32'h0400_0000, "status_wp");
        wr(OFS_CSD_TAIL, tw(0, 0, 0, 0, 2'h0, 7'h32));
        send(mk(0, 0, 12'h200), 1'b1, "tmp_cleared");
        $display("Test temporary_lock done");
        wr(OFS_CSD_TAIL, tw(0, 0, 1, 0, 2'h0, 7'h33));
        wr(OFS_CSD_TAIL, tw(1, 0, 0, 0, 2'h0, 7'h34));
        rd(OFS_CSD_TAIL, tw(1, 0, 1, 0, 2'h0, 7'h34), "copy_sticky");
        rd(OFS_STATUS, 32'h0001_0000, "status_copy");
        wr(OFS_CSD_TAIL, tw(0, 1, 1, 0, 2'h0, 7'h35));
        send(mk(0, 0, 12'h200), 1'b0, "perm_write");
        send(mk(0, 1, 12'h200), 1'b1, "perm_secure");
        wr(OFS_CSD_TAIL, tw(0, 0, 1, 0, 2'h0, 7'h36));
        rd(OFS_CSD_TAIL, tw(0, 1, 1, 0, 2'h0, 7'h36), "perm_sticky");
        rd(OFS_STATUS, 32'h0401_0000, "status_perm");
        $display("Test copy_and_permanent_lock done");
        // Extended status block: first and last words
        @(posedge ref_clk);
        esb_we   <= 1'b1;
        esb_idx  <= 4'h0;
        esb_data <= 32'hA5A5_0001;
        @(posedge ref_clk);
        esb_idx  <= 4'hF;
        esb_data <= 32'h5A5A_000F;
        @(posedge ref_clk);
        esb_we <= 1'b0;
        rd(OFS_ESB_BASE, 32'hA5A5_0001, "esb_first");
        rd(OFS_ESB_LAST, 32'h5A5A_000F, "esb_last");
        rd(OFS_ESB_BASE + 8'h04, 32'h0000_0000, "esb_other");
        $display("Test extended_status done");
        final_report();
    end
endmodule // tb_card_config_registers
